// ===== ldbpa_pkg.sv
package ldbpa_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_BOOST_LEVEL = 8'h0d;
  localparam logic [7:0] ADDR_BOOST_RATE = 8'h0e;
  localparam logic [7:0] ADDR_PATTERN_CTRL = 8'h11;
  localparam logic [7:0] ADDR_GROUP1_SCALE = 8'h12;
  localparam logic [7:0] ADDR_GROUP2_SCALE = 8'h13;
  localparam logic [7:0] ADDR_AUDIO_CTRL1 = 8'h2a;
  localparam logic [7:0] ADDR_COLOUR_MODE = 8'h0b;
  localparam logic [7:0] ADDR_ADC_DATA = 8'h0c;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] RST_BOOST_LEVEL = 8'h3f;
  localparam logic [2:0] RST_BOOST_RATE = 3'h7;
  localparam logic [3:0] RST_PATTERN_CTRL = 4'h0;
  localparam logic [5:0] RST_SCALE = 6'h00;
  localparam logic [7:0] RST_AUDIO_CTRL1 = 8'h03;
  localparam logic [1:0] RST_COLOUR_MODE = 2'h0;
  localparam logic [1:0] ADC_SRC_SINGLE = 2'h0;
  localparam logic [1:0] ADC_SRC_NONE = 2'h3;
  localparam logic [7:0] RST_ADC_DATA = 8'h00;
  // Ones in RST_BOOST_LEVEL, for the registered step count
  localparam logic [3:0] RST_BOOST_STEPS = 4'h6;
  localparam logic [1:0] MODE_SPLIT_BLINK = 2'h1;
  localparam logic [1:0] MODE_SPLIT_AUDIO = 2'h2;
  localparam logic [1:0] MODE_ALL_AUDIO = 2'h3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CURVE = 0;
  localparam int BIT_REPEAT = 1;
  localparam int BIT_RUN = 2;
  localparam int BIT_BLINK = 3;
  localparam int BIT_FOLLOW = 4;
  localparam int BIT_AGC = 3;
  localparam int BIT_SYNC = 2;

  typedef enum logic [1:0] {
    RATE_1M00,
    RATE_1M67,
    RATE_2M00
  } ldbpa_rate_type;

  typedef struct packed {
    logic [1:0] red;
    logic [1:0] green;
    logic [1:0] blue;
  } ldbpa_scale_type;

  typedef struct packed {
    logic [2:0] gain;
    logic followFreq;
    logic agcEnable;
    logic syncEnable;
    logic [1:0] adcSource;
  } ldbpa_audio_type;

  typedef struct packed {
    logic blinkEnable;
    logic runEnable;
    logic repeatEnable;
    logic curveSelect;
  } ldbpa_pattern_type;
endpackage

// ===== ldbpa_regs.sv
`timescale 1ns/1ps
module ldbpa_regs
  import ldbpa_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [7:0] adcSample,
  input wire logic adcSampleValid,
  output logic [7:0] boostLevel,
  output logic boostLevelValid,
  output ldbpa_rate_type boostRate,
  output logic [3:0] boostSteps,
  output ldbpa_pattern_type patternCtrl,
  output logic patternStart,
  output ldbpa_scale_type group1Scale,
  output ldbpa_scale_type group2Scale,
  output ldbpa_audio_type audioCtrl,
  output logic audioInputOn,
  output logic [1:0] colourMode,
  output logic group1Audio,
  output logic group2Audio,
  output logic group1Blink
);
  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] boost_r, boost_nxt;
  logic [2:0] rate_r, rate_nxt;
  ldbpa_pattern_type pat_r, pat_nxt;
  ldbpa_scale_type g1_r, g1_nxt, g2_r, g2_nxt;
  ldbpa_audio_type aud_r, aud_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [7:0] adc_r, adc_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic start_r, start_nxt;

  always_comb begin
    boost_nxt = boost_r;
    rate_nxt = rate_r;
    pat_nxt = pat_r;
    g1_nxt = g1_r;
    g2_nxt = g2_r;
    aud_nxt = aud_r;
    mode_nxt = mode_r;
    adc_nxt = adc_r;
    start_nxt = 1'b0;
    if (adcSampleValid) begin
      adc_nxt = adcSample;
    end
    if (regWrite) begin
      if (regAddr == ADDR_BOOST_LEVEL) begin
        boost_nxt = regWdata;
      end else if (regAddr == ADDR_BOOST_RATE) begin
        rate_nxt = regWdata[2:0];
      end else if (regAddr == ADDR_PATTERN_CTRL) begin
        pat_nxt = regWdata[3:0];
        // Only a rising run bit restarts at command one
        start_nxt = regWdata[BIT_RUN] && !pat_r.runEnable;
      end else if (regAddr == ADDR_GROUP1_SCALE) begin
        g1_nxt = regWdata[5:0];
      end else if (regAddr == ADDR_GROUP2_SCALE) begin
        g2_nxt = regWdata[5:0];
      end else if (regAddr == ADDR_AUDIO_CTRL1) begin
        aud_nxt = regWdata;
      end else if (regAddr == ADDR_COLOUR_MODE) begin
        mode_nxt = regWdata[1:0];
      end
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (regRead) begin
      if (regAddr == ADDR_BOOST_LEVEL) begin
        rdata_nxt = boost_r;
      end else if (regAddr == ADDR_BOOST_RATE) begin
        rdata_nxt = {5'h00, rate_r};
      end else if (regAddr == ADDR_PATTERN_CTRL) begin
        rdata_nxt = {4'h0, pat_r};
      end else if (regAddr == ADDR_GROUP1_SCALE) begin
        rdata_nxt = {2'h0, g1_r};
      end else if (regAddr == ADDR_GROUP2_SCALE) begin
        rdata_nxt = {2'h0, g2_r};
      end else if (regAddr == ADDR_AUDIO_CTRL1) begin
        rdata_nxt = aud_r;
      end else if (regAddr == ADDR_COLOUR_MODE) begin
        rdata_nxt = {6'h00, mode_r};
      end else if (regAddr == ADDR_ADC_DATA) begin
        rdata_nxt = adc_r;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      boost_r <= RST_BOOST_LEVEL;
      rate_r <= RST_BOOST_RATE;
      pat_r <= RST_PATTERN_CTRL;
      g1_r <= RST_SCALE;
      g2_r <= RST_SCALE;
      aud_r <= RST_AUDIO_CTRL1;
      mode_r <= RST_COLOUR_MODE;
      adc_r <= RST_ADC_DATA;
      rdata_r <= 8'h00;
      start_r <= 1'b0;
    end else begin
      boost_r <= boost_nxt;
      rate_r <= rate_nxt;
      pat_r <= pat_nxt;
      g1_r <= g1_nxt;
      g2_r <= g2_nxt;
      aud_r <= aud_nxt;
      mode_r <= mode_nxt;
      adc_r <= adc_nxt;
      rdata_r <= rdata_nxt;
      start_r <= start_nxt;
    end
  end

  // ****************************************
  // Decoded controls
  // ****************************************
  function automatic logic [3:0] countOnes(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // Decodes register from next values, so they move on the same edge as their source
  ldbpa_rate_type rateDec_r, rateDec_nxt;
  logic [3:0] steps_r, steps_nxt;
  logic levelOk_r, levelOk_nxt;
  logic audioOn_r, audioOn_nxt;
  logic g1Audio_r, g1Audio_nxt;
  logic g2Audio_r, g2Audio_nxt;
  logic g1Blink_r, g1Blink_nxt;

  always_comb begin
    // Upper bits decide; the lowest bit never matters
    if (rate_nxt[2]) begin
      rateDec_nxt = RATE_2M00;
    end else if (rate_nxt[1]) begin
      rateDec_nxt = RATE_1M67;
    end else begin
      rateDec_nxt = RATE_1M00;
    end
    // Non-thermometer codes are flagged, not corrected
    levelOk_nxt = ((boost_nxt & (boost_nxt + 8'h01)) == 8'h00);
    steps_nxt = countOnes(boost_nxt);
    audioOn_nxt = aud_nxt.syncEnable && (aud_nxt.adcSource == ADC_SRC_SINGLE);
    g1Audio_nxt = (mode_nxt == MODE_ALL_AUDIO);
    g2Audio_nxt = (mode_nxt == MODE_SPLIT_AUDIO) || (mode_nxt == MODE_ALL_AUDIO);
    g1Blink_nxt = (mode_nxt == MODE_SPLIT_BLINK) && pat_nxt.blinkEnable;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // Must agree with the reset codes held in the registers above
      rateDec_r <= RATE_2M00;
      steps_r <= RST_BOOST_STEPS;
      levelOk_r <= 1'b1;
      audioOn_r <= 1'b0;
      g1Audio_r <= 1'b0;
      g2Audio_r <= 1'b0;
      g1Blink_r <= 1'b0;
    end else begin
      rateDec_r <= rateDec_nxt;
      steps_r <= steps_nxt;
      levelOk_r <= levelOk_nxt;
      audioOn_r <= audioOn_nxt;
      g1Audio_r <= g1Audio_nxt;
      g2Audio_r <= g2Audio_nxt;
      g1Blink_r <= g1Blink_nxt;
    end
  end

  assign boostRate = rateDec_r;
  assign boostLevelValid = levelOk_r;
  assign boostSteps = steps_r;
  assign boostLevel = boost_r;
  assign patternCtrl = pat_r;
  assign patternStart = start_r;
  assign group1Scale = g1_r;
  assign group2Scale = g2_r;
  assign audioCtrl = aud_r;
  assign audioInputOn = audioOn_r;
  assign colourMode = mode_r;
  assign group1Audio = g1Audio_r;
  assign group2Audio = g2Audio_r;
  assign group1Blink = g1Blink_r;
  assign regRdata = rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  reset_values_a: assert property (@(posedge mclk) $rose(resetn) |->
    boost_r == RST_BOOST_LEVEL && aud_r.adcSource == ADC_SRC_NONE && rate_r == RST_BOOST_RATE)
    else $error("reset values wrong");
  reset_decode_a: assert property (@(posedge mclk) $rose(resetn) |->
    boostSteps == RST_BOOST_STEPS && boostRate == RATE_2M00 && !audioInputOn)
    else $error("reset decode wrong");
  boost_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && regAddr == ADDR_BOOST_LEVEL |=> boostLevel == $past(regWdata))
    else $error("boost write lost");
  thermo_steps_a: assert property (@(posedge mclk) disable iff (!resetn)
    boostLevelValid |-> boostLevel == 8'((9'h001 << boostSteps) - 9'h001))
    else $error("boost step count wrong");
  rate_decode_a: assert property (@(posedge mclk) disable iff (!resetn)
    rate_r[2] |-> boostRate == RATE_2M00)
    else $error("rate decode wrong");
  rate_mid_a: assert property (@(posedge mclk) disable iff (!resetn)
    !rate_r[2] && rate_r[1] |-> boostRate == RATE_1M67)
    else $error("middle rate decode wrong");
  rate_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    rate_r[2:1] == 2'h0 |-> boostRate == RATE_1M00)
    else $error("low rate decode wrong");
  run_start_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && regAddr == ADDR_PATTERN_CTRL && regWdata[BIT_RUN] && !pat_r.runEnable
    |=> patternStart ##1 !patternStart)
    else $error("start pulse wrong");
  start_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
    patternStart |-> patternCtrl.runEnable && !$past(patternCtrl.runEnable))
    else $error("start without rising run bit");
  pattern_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && regAddr == ADDR_PATTERN_CTRL |=> patternCtrl == $past(regWdata[3:0]))
    else $error("pattern write lost");
  scale_one_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && regAddr == ADDR_GROUP1_SCALE |=> group1Scale == $past(regWdata[5:0]))
    else $error("group one scale lost");
  scale_two_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && regAddr == ADDR_GROUP2_SCALE |=> group2Scale == $past(regWdata[5:0]))
    else $error("group two scale lost");
  audio_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && regAddr == ADDR_AUDIO_CTRL1 |=> audioCtrl.gain == $past(regWdata[7:5]))
    else $error("gain write lost");
  follow_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && regAddr == ADDR_AUDIO_CTRL1 |=>
    {audioCtrl.followFreq, audioCtrl.agcEnable, audioCtrl.syncEnable} ==
    $past(regWdata[BIT_FOLLOW:BIT_SYNC]))
    else $error("audio enables lost");
  audio_source_a: assert property (@(posedge mclk) disable iff (!resetn)
    audioInputOn |-> audioCtrl.syncEnable && audioCtrl.adcSource == ADC_SRC_SINGLE)
    else $error("audio input on wrongly");
  adc_readback_a: assert property (@(posedge mclk) disable iff (!resetn)
    adcSampleValid ##1 !adcSampleValid ##1
    (regRead && regAddr == ADDR_ADC_DATA && !adcSampleValid)
    |=> regRdata == $past(adcSample, 3))
    else $error("adc readback wrong");
  adc_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && regAddr == ADDR_ADC_DATA && !adcSampleValid |=> adc_r == $past(adc_r))
    else $error("adc data overwritten");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
    $past(regRead) && $past(regAddr) == ADDR_GROUP1_SCALE |-> regRdata[7:6] == 2'h0)
    else $error("reserved bits set");
  reserved_rate_a: assert property (@(posedge mclk) disable iff (!resetn)
    $past(regRead) && $past(regAddr) == ADDR_BOOST_RATE |-> regRdata[7:3] == 5'h00)
    else $error("rate reserved bits set");
  rdata_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    !$past(regRead) |-> regRdata == 8'h00)
    else $error("read data not cleared");
  mode_audio_a: assert property (@(posedge mclk) disable iff (!resetn)
    group1Audio |-> group2Audio)
    else $error("colour mode wrong");
  group2_audio_a: assert property (@(posedge mclk) disable iff (!resetn)
    group2Audio |-> colourMode == MODE_SPLIT_AUDIO || colourMode == MODE_ALL_AUDIO)
    else $error("group two audio wrong");
  blink_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    group1Blink |-> colourMode == MODE_SPLIT_BLINK && patternCtrl.blinkEnable)
    else $error("blink select wrong");

  // ****************************************
  // Cover points
  // ****************************************
  cover_start_c: cover property (@(posedge mclk) disable iff (!resetn) patternStart);
  cover_freq_c: cover property (@(posedge mclk) disable iff (!resetn) boostRate == RATE_1M67);
  cover_audio_c: cover property (@(posedge mclk) disable iff (!resetn) audioInputOn);
  cover_blink_c: cover property (@(posedge mclk) disable iff (!resetn) group1Blink);
  cover_adc_c: cover property (@(posedge mclk) disable iff (!resetn)
    adcSampleValid ##2 (regRead && regAddr == ADDR_ADC_DATA));
endmodule

// ===== ldbpa_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host side of the register port
// ****************************************
module ldbpa_host_model
  import ldbpa_pkg::*;
(
  input wire logic mclk,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge mclk);
    #1;
    regWrite = 1'b0;
    // Idle lines flip so stale values never look live
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge mclk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    d = regRdata;
  endtask
endmodule

// ===== tb_led_driver_boost_pattern_audio_regs.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    badCount++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); \
  end \
end
module tb_led_driver_boost_pattern_audio_regs
  import ldbpa_pkg::*;
;
  logic mclk, resetn, regWrite, regRead, adcSampleValid, boostLevelValid, patternStart;
  logic audioInputOn, group1Audio, group2Audio, group1Blink;
  logic [7:0] regAddr, regWdata, regRdata, adcSample, boostLevel, rv, d;
  logic [3:0] boostSteps;
  logic [1:0] colourMode;
  ldbpa_rate_type boostRate;
  ldbpa_pattern_type patternCtrl;
  ldbpa_scale_type group1Scale, group2Scale;
  ldbpa_audio_type audioCtrl;
  int badCount = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] mapA [8] = '{8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13, 8'h2a, 8'h0b, 8'h0c};
  logic [7:0] rstV [8] = '{8'h3f, 8'h07, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
  ldbpa_regs DUT (.mclk, .resetn, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
    .adcSample, .adcSampleValid, .boostLevel, .boostLevelValid, .boostRate, .boostSteps,
    .patternCtrl, .patternStart, .group1Scale, .group2Scale, .audioCtrl, .audioInputOn,
    .colourMode, .group1Audio, .group2Audio, .group1Blink);
  ldbpa_host_model host (.mclk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic ldbpa_rate_type rateOf(input logic [2:0] f);
    if (f[2]) return RATE_2M00;
    if (f[1]) return RATE_1M67;
    return RATE_1M00;
  endfunction
  task automatic wrChk(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
    logic [7:0] got;
    host.wr(a, v);
    host.rd(a, got);
    `CHK("readback", v & m, got)
  endtask
  task automatic resetChk();
    for (int i = 0; i < 8; i++) begin
      host.rd(mapA[i], d);
      `CHK("resetValue", rstV[i], d)
    end
    `CHK("resetSteps", 4'h6, boostSteps)
    `CHK("resetRate", RATE_2M00, boostRate)
    `CHK("resetAudioOn", 1'b0, audioInputOn)
  endtask
  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      giveVerdict();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    adcSample = 8'h00;
    adcSampleValid = 1'b0;
    rv = 8'($urandom(32'hb3c698df));
    repeat (8) @(posedge mclk);
    #1 resetn = 1'b1;
    resetChk();
    host.rd(8'h2b, d);
    `CHK("unmapped", 8'h00, d)
    for (int i = 0; i <= 8; i++) begin
      rv = 8'((16'h1 << i) - 1);
      host.wr(ADDR_BOOST_LEVEL, rv);
      `CHK("boostLevel", rv, boostLevel)
      `CHK("boostSteps", 4'(i), boostSteps)
      `CHK("boostValid", 1'b1, boostLevelValid)
    end
    for (int i = 0; i < 8; i++) begin
      wrChk(ADDR_BOOST_RATE, {5'($urandom), 3'(i)}, 8'h07);
      `CHK("boostRate", rateOf(3'(i)), boostRate)
    end
    host.wr(ADDR_PATTERN_CTRL, 8'h00);
    host.wr(ADDR_PATTERN_CTRL, 8'hf4);
    `CHK("startPulse", 1'b1, patternStart)
    @(posedge mclk);
    #1;
    `CHK("startEnd", 1'b0, patternStart)
    host.wr(ADDR_PATTERN_CTRL, 8'h04);
    `CHK("noRestart", 1'b0, patternStart)
    for (int k = 0; k < 12; k++) begin
      rv = 8'($urandom);
      rv[2] = k[0];
      rv[1:0] = {2{k[1]}};
      wrChk(ADDR_PATTERN_CTRL, rv, 8'h0f);
      `CHK("patternCtrl", rv[3:0], patternCtrl)
      wrChk(ADDR_GROUP1_SCALE, rv, 8'h3f);
      `CHK("group1Scale", rv[5:0], group1Scale)
      wrChk(ADDR_GROUP2_SCALE, ~rv, 8'h3f);
      `CHK("group2Scale", 6'(~rv), group2Scale)
      wrChk(ADDR_AUDIO_CTRL1, rv, 8'hff);
      `CHK("audioCtrl", rv, audioCtrl)
      `CHK("audioOn", rv[2] && rv[1:0] == 2'b00, audioInputOn)
    end
    host.wr(ADDR_PATTERN_CTRL, 8'h08);
    for (int m = 0; m < 4; m++) begin
      wrChk(ADDR_COLOUR_MODE, {6'($urandom), 2'(m)}, 8'h03);
      `CHK("group1Audio", m == 3, group1Audio)
      `CHK("group2Audio", m >= 2, group2Audio)
      `CHK("group1Blink", m == 1, group1Blink)
      `CHK("colourMode", 2'(m), colourMode)
    end
    rv = 8'($urandom);
    @(posedge mclk);
    #1;
    adcSample = rv;
    adcSampleValid = 1'b1;
    @(posedge mclk);
    #1;
    adcSampleValid = 1'b0;
    adcSample = ~rv;
    host.rd(ADDR_ADC_DATA, d);
    `CHK("adcData", rv, d)
    // Data register must shrug off host writes
    host.wr(ADDR_ADC_DATA, ~rv);
    host.rd(ADDR_ADC_DATA, d);
    `CHK("adcReadOnly", rv, d)
    // Mid-run reset must bring every register and the step, rate and audio decodes back
    resetn = 1'b0;
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    resetChk();
    giveVerdict();
  end
endmodule
